// [design/ecss_event_channel_source_select.sv]
// What this block does
// - Bits 22:16 pick the channel's generator
// - Generator code zero connects no source
// - Codes 01-0B are counter sources; 0C reserved
// - 0D-1B irq lines, 1E-21 DMA channels
// - 22-3B timers, 42-4C analog; others reserved
// - Bits 15:9 read zero; software writes zeros
// - Bit 8 injects event on written channel
// - Soft event travels like a generator event
// - Zero write does nothing; bit reads zero
// - Bits 3:0 name channel set or read
// - Path field: sync, resync, async, reserved
// - Edge field: none, rise, fall, both
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module ecss_event_channel_source_select
  import ecss_pkg::*;
(
  input wire logic clk, // 50 MHz bus clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [ECSS_NUM_GEN-1:0] gen_lines, // Generator levels, bit n is code n
  output logic [ECSS_NUM_CHAN-1:0] chan_event, // Per-channel event output
  output logic clock_keep_on // Channel clocks requested always
);

  // ==========================================================
  // Functions
  // True when a generator code names a real source
  function automatic logic gen_valid(input logic [6:0] code);
    logic ok;
    ok = 1'b0;
    if (code >= ECSS_GEN_RTC_FIRST && code <= ECSS_GEN_RTC_LAST) begin
      ok = 1'b1;
    end
    if (code >= ECSS_GEN_IRQ_FIRST && code <= ECSS_GEN_IRQ_LAST) begin
      ok = 1'b1;
    end
    if (code >= ECSS_GEN_DMA_FIRST && code <= ECSS_GEN_TMR_LAST) begin
      ok = 1'b1;
    end
    if (code >= ECSS_GEN_ANA_FIRST && code <= ECSS_GEN_ANA_LAST) begin
      ok = 1'b1;
    end
    return ok; // Code zero and reserved codes fall through
  endfunction

  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // Register state
  ecss_cfg_t cfg [ECSS_NUM_CHAN];
  ecss_cfg_t next_cfg [ECSS_NUM_CHAN];
  logic [3:0] chan_ptr;
  logic [3:0] next_chan_ptr;
  logic clk_on;
  logic next_clk_on;
  logic [ECSS_NUM_CHAN-1:0] sw_pulse;
  logic [ECSS_NUM_CHAN-1:0] next_sw_pulse;
  logic ack;
  logic next_ack;
  logic [31:0] rd_data;
  logic [31:0] next_rd_data;

  logic req;
  logic wr_now;
  logic [31:0] chan_word;
  logic [31:0] wr_word;
  logic [3:0] tgt_chan;

  // Current word of the pointed channel as seen on a read
  always_comb begin
    chan_word = 32'h0000_0000; // Reserved bits and soft event bit read zero
    chan_word[ECSS_CH_SEL_LSB +: 4] = chan_ptr;
    if (chan_ptr < 4'(ECSS_NUM_CHAN)) begin
      chan_word[ECSS_GEN_LSB +: 7] = cfg[chan_ptr].generator_select;
      chan_word[ECSS_PATH_LSB +: 2] = cfg[chan_ptr].path;
      chan_word[ECSS_EDGE_LSB +: 2] = cfg[chan_ptr].edge_detect_kind;
    end
  end

  // Bus request decode; writes act at the edge where ack is high
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_now = req & ack & wb_we_i;
  assign wr_word = lane_merge(chan_word, wb_dat_i, wb_sel_i);
  assign tgt_chan = wr_word[ECSS_CH_SEL_LSB +: 4]; // Channel of this same write

  // ==========================================================
  // Next-state of the register file and bus answer
  always_comb begin
    next_cfg = cfg;
    next_chan_ptr = chan_ptr;
    next_clk_on = clk_on;
    next_sw_pulse = '0;
    next_ack = req & ~ack;
    next_rd_data = rd_data;
    if (req & ~ack) begin
      next_rd_data = 32'h0000_0000; // Unmapped addresses read zero
      if (wb_adr_i == ECSS_OFS_CTRL) begin
        next_rd_data[ECSS_CTRL_CLKON_BIT] = clk_on;
      end else if (wb_adr_i == ECSS_OFS_CHAN) begin
        next_rd_data = chan_word;
      end
    end
    if (wr_now && wb_adr_i == ECSS_OFS_CHAN) begin
      if (wb_sel_i[0]) begin
        next_chan_ptr = tgt_chan;
      end
      if (tgt_chan < 4'(ECSS_NUM_CHAN)) begin
        // Only lanes written update fields; bits 15:9 are never stored
        if (wb_sel_i[2]) begin
          next_cfg[tgt_chan].generator_select = wr_word[ECSS_GEN_LSB +: 7];
        end
        if (wb_sel_i[3]) begin
          next_cfg[tgt_chan].path = ecss_path_t'(wr_word[ECSS_PATH_LSB +: 2]);
          next_cfg[tgt_chan].edge_detect_kind = ecss_edge_t'(wr_word[ECSS_EDGE_LSB +: 2]);
        end
        if (wb_sel_i[1] && wb_dat_i[ECSS_SOFT_EVENT_INSERT_BIT]) begin
          next_sw_pulse[tgt_chan] = 1'b1; // One-shot injection; zero does nothing
        end
      end
    end
    if (wr_now && wb_adr_i == ECSS_OFS_CTRL && wb_sel_i[0]) begin
      next_clk_on = wb_dat_i[ECSS_CTRL_CLKON_BIT];
      if (wb_dat_i[ECSS_CTRL_SWRST_BIT]) begin
        // Software reset returns every register to its reset value
        for (int c = 0; c < ECSS_NUM_CHAN; c++) begin
          next_cfg[c] = ECSS_CFG_RESET;
        end
        next_chan_ptr = 4'h0;
        next_clk_on = ECSS_CTRL_RESET[ECSS_CTRL_CLKON_BIT];
        next_sw_pulse = '0;
      end
    end
  end

  // Register file flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int c = 0; c < ECSS_NUM_CHAN; c++) begin
        cfg[c] <= ECSS_CFG_RESET;
      end
      chan_ptr <= 4'h0;
      clk_on <= 1'b0;
      sw_pulse <= '0;
      ack <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      chan_ptr <= next_chan_ptr;
      clk_on <= next_clk_on;
      sw_pulse <= next_sw_pulse;
      ack <= next_ack;
      rd_data <= next_rd_data;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;
  assign clock_keep_on = clk_on;

  // ==========================================================
  // Resynchronizer for generator levels
  logic [ECSS_NUM_GEN-1:0] sync_a;
  logic [ECSS_NUM_GEN-1:0] sync_b;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= gen_lines;
      sync_b <= sync_a;
    end
  end

  // ==========================================================
  // Per-channel source selection and edge detection
  logic [ECSS_NUM_CHAN-1:0] sel_level;
  logic [ECSS_NUM_CHAN-1:0] prev_level;
  logic [ECSS_NUM_CHAN-1:0] next_prev_level;
  logic [ECSS_NUM_CHAN-1:0] next_chan_event;

  always_comb begin
    for (int c = 0; c < ECSS_NUM_CHAN; c++) begin
      sel_level[c] = 1'b0;
      if (gen_valid(cfg[c].generator_select)) begin
        // Resync path takes the two-flop copy
        if (cfg[c].path == ECSS_PATH_RESYNC) begin
          sel_level[c] = sync_b[cfg[c].generator_select];
        end else begin
          sel_level[c] = gen_lines[cfg[c].generator_select];
        end
      end
      next_prev_level[c] = sel_level[c];
      next_chan_event[c] = 1'b0;
      unique case (cfg[c].path)
        ECSS_PATH_SYNC, ECSS_PATH_RESYNC: begin
          unique case (cfg[c].edge_detect_kind)
            ECSS_EDGE_NONE: next_chan_event[c] = 1'b0;
            ECSS_EDGE_RISE: next_chan_event[c] = sel_level[c] & ~prev_level[c];
            ECSS_EDGE_FALL: next_chan_event[c] = ~sel_level[c] & prev_level[c];
            ECSS_EDGE_BOTH: next_chan_event[c] = sel_level[c] ^ prev_level[c];
          endcase
          next_chan_event[c] = next_chan_event[c] | sw_pulse[c];
        end
        ECSS_PATH_ASYNC: next_chan_event[c] = sel_level[c] | sw_pulse[c]; // Level passes
        ECSS_PATH_RSVD: next_chan_event[c] = 1'b0;
      endcase
    end
  end

  // Channel output flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_level <= '0;
      chan_event <= '0;
    end else begin
      prev_level <= next_prev_level;
      chan_event <= next_chan_event;
    end
  end

endmodule

// [design/ecss_pkg.sv]
package ecss_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] ECSS_OFS_CTRL = 4'h0;
  localparam logic [3:0] ECSS_OFS_CHAN = 4'h4;
  localparam logic [7:0] ECSS_CTRL_RESET = 8'h00;
  localparam int ECSS_CTRL_SWRST_BIT = 0;
  localparam int ECSS_CTRL_CLKON_BIT = 4;
  // ==========================================================
  // Channel configuration word fields
  localparam int ECSS_CH_SEL_LSB = 0;
  localparam int ECSS_SOFT_EVENT_INSERT_BIT = 8;
  localparam int ECSS_GEN_LSB = 16;
  localparam int ECSS_PATH_LSB = 24;
  localparam int ECSS_EDGE_LSB = 26;
  localparam int ECSS_NUM_CHAN = 12;
  localparam int ECSS_NUM_GEN = 128;
  // ==========================================================
  // Generator code ranges
  localparam logic [6:0] ECSS_GEN_NONE = 7'h00;
  localparam logic [6:0] ECSS_GEN_RTC_FIRST = 7'h01;
  localparam logic [6:0] ECSS_GEN_RTC_LAST = 7'h0B;
  localparam logic [6:0] ECSS_GEN_IRQ_FIRST = 7'h0D;
  localparam logic [6:0] ECSS_GEN_IRQ_LAST = 7'h1B;
  localparam logic [6:0] ECSS_GEN_DMA_FIRST = 7'h1E;
  localparam logic [6:0] ECSS_GEN_TMR_LAST = 7'h3B;
  localparam logic [6:0] ECSS_GEN_ANA_FIRST = 7'h42;
  localparam logic [6:0] ECSS_GEN_ANA_LAST = 7'h4C;
  // ==========================================================
  // Field encodings
  typedef enum logic [1:0] {
    ECSS_PATH_SYNC = 2'h0,
    ECSS_PATH_RESYNC = 2'h1,
    ECSS_PATH_ASYNC = 2'h2,
    ECSS_PATH_RSVD = 2'h3
  } ecss_path_t;
  typedef enum logic [1:0] {
    ECSS_EDGE_NONE = 2'h0,
    ECSS_EDGE_RISE = 2'h1,
    ECSS_EDGE_FALL = 2'h2,
    ECSS_EDGE_BOTH = 2'h3
  } ecss_edge_t;
  // Stored configuration of one channel
  typedef struct packed {
    ecss_edge_t edge_detect_kind;
    ecss_path_t path;
    logic [6:0] generator_select;
  } ecss_cfg_t;
  localparam ecss_cfg_t ECSS_CFG_RESET = '{ECSS_EDGE_NONE, ECSS_PATH_SYNC, 7'h00};
endpackage

// [sim/ecss_gen_model.sv]
`timescale 1ns/100ps
module ecss_gen_model
  import ecss_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic [6:0] code, // Generator that moves
  input wire logic lvl, // Level of that generator
  output logic [ECSS_NUM_GEN-1:0] gen_lines // Generator levels
);
  // ==========================================================
  // Generator levels
  logic [ECSS_NUM_GEN-1:0] next_gen_lines;
  // One generator follows the level, all others rest low
  always_comb begin
    next_gen_lines = '0;
    next_gen_lines[code] = lvl;
  end
  // Levels leave the generators registered
  always_ff @(posedge clk) begin
    gen_lines <= next_gen_lines;
  end
endmodule

// [sim/ecss_chk.sv]
`timescale 1ns/100ps
module ecss_chk
  import ecss_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rstn, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [ECSS_NUM_GEN-1:0] gen_lines, // Generator levels
  input wire logic [ECSS_NUM_CHAN-1:0] chan_event // Channel events
);
  // ==========================================================
  // Bus and channel properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic rd4;
  assign rd4 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h4;
  property p_ack_once; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack late");
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  property p_rd_soft_event_insert; rd4 |-> !wb_dat_o[8]; endproperty
  a_rd_soft_event_insert: assert property (p_rd_soft_event_insert) else $error("soft event bit reads one");
  property p_rd_mid; rd4 |-> wb_dat_o[15:9] == 7'h00; endproperty
  a_rd_mid: assert property (p_rd_mid) else $error("bits 15:9 read nonzero");
  property p_rd_hi; rd4 |-> wb_dat_o[31:28] == 4'h0 && !wb_dat_o[23]; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper spare bits read nonzero");
  property p_rd_chan; rd4 |-> wb_dat_o[7:4] == 4'h0; endproperty
  a_rd_chan: assert property (p_rd_chan) else $error("bits 7:4 read nonzero");
  property p_quiet; (gen_lines == '0 && !wb_cyc_i)[*5] |=> chan_event == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("event with no cause");
  property p_soft_event_insert;
    (wb_ack_o && wb_we_i && wb_adr_i == 4'h4 && wb_sel_i[1:0] == 2'h3 && wb_dat_i[8] && wb_dat_i[3:0] < 4'hC)
      |-> ##2 chan_event[$past(wb_dat_i[3:0], 2)];
  endproperty
  a_soft_event_insert: assert property (p_soft_event_insert) else $error("soft event missing");
  c_soft_event_insert: cover property (wb_ack_o && wb_we_i && wb_dat_i[8]);
  c_read: cover property (rd4);
  c_event: cover property (chan_event != '0);
endmodule
bind ecss_event_channel_source_select ecss_chk i_chk (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gen_lines(gen_lines), .chan_event(chan_event));

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top import ecss_pkg::*;;
  typedef struct packed {logic [6:0] code; logic [1:0] path; logic [1:0] edg; logic [1:0] n;} ecss_row_t;
  logic clk = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, lvl = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [6:0] code = 7'h00;
  logic clock_keep_on;
  logic [ECSS_NUM_GEN-1:0] gen_lines;
  logic [ECSS_NUM_CHAN-1:0] chan_event;
  int num_errors = 0, num_checks = 0, cnt, ch;
  // Codes, path, edge kind and pulses expected for one rise and fall of the source
  ecss_row_t rows [16] = '{'{7'h01, 2'h0, 2'h1, 2'h1}, '{7'h0B, 2'h0, 2'h3, 2'h2}, '{7'h0C, 2'h0, 2'h3, 2'h0},
    '{7'h0D, 2'h0, 2'h1, 2'h1}, '{7'h1C, 2'h0, 2'h3, 2'h0}, '{7'h21, 2'h0, 2'h2, 2'h1}, '{7'h22, 2'h0, 2'h3, 2'h2},
    '{7'h3B, 2'h0, 2'h1, 2'h1}, '{7'h3C, 2'h0, 2'h3, 2'h0}, '{7'h42, 2'h0, 2'h1, 2'h1}, '{7'h4C, 2'h0, 2'h2, 2'h1},
    '{7'h4D, 2'h0, 2'h3, 2'h0}, '{7'h00, 2'h0, 2'h3, 2'h0}, '{7'h01, 2'h0, 2'h0, 2'h0}, '{7'h05, 2'h1, 2'h3, 2'h2},
    '{7'h05, 2'h3, 2'h3, 2'h0}};
  // Clock and instances
  always #10 clk = ~clk;
  ecss_event_channel_source_select i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .gen_lines(gen_lines), .chan_event(chan_event), .clock_keep_on(clock_keep_on));
  ecss_gen_model i_gen (.clk(clk), .code(code), .lvl(lvl), .gen_lines(gen_lines));
  // ==========================================================
  // Tasks
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic count(input int c, input int len);
    repeat (len) begin
      @(posedge clk);
      if (chan_event[c] === 1'b1) cnt++;
    end
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("chan_reset", rd, 32'h0);
    // Each row moves its source once up and once down
    for (int i = 0; i < 16; i++) begin
      cnt = 0;
      ch = i % 12;
      code <= rows[i].code;
      wb(1'b1, 4'h4, 4'hF, {4'h0, rows[i].edg, rows[i].path, 1'b0, rows[i].code, 12'h000, 4'(ch)});
      lvl <= 1'b1;
      count(ch, 6);
      lvl <= 1'b0;
      count(ch, 6);
      check("row_pulses", 32'(cnt), 32'(rows[i].n));
    end
    // Soft event with the channel in the same 16-bit write, then a zero write
    cnt = 0;
    wb(1'b1, 4'h4, 4'h3, 32'h0000_0105);
    count(5, 6);
    check("soft_event", 32'(cnt), 32'h1);
    wb(1'b1, 4'h4, 4'h3, 32'h0000_0005);
    count(5, 6);
    check("zero_write", 32'(cnt), 32'h1);
    // Readback through a byte write of the channel number
    wb(1'b1, 4'h4, 4'h1, 32'h0000_0004);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("cfg_ch4", rd, 32'h0C1C_0004);
    wb(1'b1, 4'h4, 4'hF, 32'h017F_0107);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("cfg_ch7", rd, 32'h017F_0007);
    wb(1'b1, 4'h4, 4'h1, 32'h0000_000C);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("cfg_ch12", rd, 32'h0000_000C);
    // Software reset clears the stored configuration
    wb(1'b1, 4'h0, 4'h1, 32'h0000_0001);
    wb(1'b1, 4'h4, 4'h1, 32'h0000_0004);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("cfg_swrst", rd, 32'h0000_0004);
    // Keep-on bit reads back and reaches its pin
    wb(1'b1, 4'h0, 4'h1, 32'h0000_0010);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    check("ctrl_keep_on", rd, 32'h0000_0010);
    check("keep_on_pin", 32'(clock_keep_on), 32'h1);
    // Reset in mid-run clears pointer and keep-on bit
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    check("ctrl_after_rst", rd, 32'h0000_0000);
    check("keep_on_after_rst", 32'(clock_keep_on), 32'h0);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    check("chan_after_rst", rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
